// [hdl/cll_map.svh]
// Register offsets, field positions and reset values of the comparator unit
`ifndef CLL_MAP_SVH
`define CLL_MAP_SVH
`define CLL_OFS_RDC 8'h78
`define CLL_OFS_MUX 8'h79
`define CLL_OFS_ENA 8'h7A
`define CLL_OFS_OPT 8'h7B
`define CLL_OFS_FUN 8'h7C
`define CLL_OFS_IST 8'h7D
`define CLL_OFS_IMK 8'h7E
`define CLL_RST8 8'h00
`define CLL_RDC_L0 0
`define CLL_RDC_L1 1
`define CLL_RDC_D0 4
`define CLL_RDC_D1 5
`define CLL_ENA_0 0
`define CLL_ENA_1 4
`define CLL_OPT_DS0 0
`define CLL_OPT_RS0 1
`define CLL_OPT_PIN0 2
`define CLL_OPT_INT0 3
`define CLL_OPT_DS1 4
`define CLL_OPT_RS1 5
`define CLL_OPT_PIN1 6
`define CLL_OPT_INT1 7
`define CLL_ENA_MASK 8'h11
`define CLL_IST_MASK 8'h03
`define CLL_ADDR_MASK 8'hFF
`endif

// [hdl/cll_pkg.sv]
// Types shared by the comparator logic and latch unit
package cll_pkg;
  typedef logic [3:0] cll_func_t;
  typedef logic [7:0] cll_reg_t;
endpackage

// [hdl/cll_comparator_unit.sv]
// Comparator truth tables, latches, routing and register slave
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`include "cll_map.svh"
// Summary of operation
// - Each channel applies one of 16 functions to own and neighbour inputs.
// - Truth-table output high sets that channel's latch.
// - In write-clear mode, writing zero to latched bit clears it.
// - Channel 1 latch clears by write or channel 0 rising edge.
// - Channel 0 latch clears by write or channel 1 rising edge.
// - Output-source bits pick raw or latched main output.
// - Pin-source bits pick raw or latched value for GPIO pin.
// - Read/clear bits 5 and 4 show live comparator state.
// - Read/clear bits 1 and 0 show latched state.
// - Enable bits 4 and 0 switch comparators on.
// - Input-select register holds four two-bit source fields.
// - Function register holds channel 1 high nibble, channel 0 low.
// - Codes 0000 false, 0011 A, 0101 B, 1111 true.
// - Codes 0110 xor, 0111 or, 1000 nor.
// - Main output goes to sensing logic and interrupt controller.
module cll_comparator_unit
  import cll_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Avalon-MM slave
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Analog comparator side
  input wire logic [1:0] i_cmp_raw,
  output logic [1:0] o_cmp_enable,
  output logic [1:0] o_ch0_input_sel_p,
  output logic [1:0] o_ch0_input_sel_n,
  output logic [1:0] o_ch1_input_sel_p,
  output logic [1:0] o_ch1_input_sel_n,
  output logic [1:0] o_analog_out_connect,
  // Routed results
  output logic [1:0] o_main_out,
  output logic [1:0] o_pin_out,
  output logic o_irq
);

  logic rst_s1_q;
  logic rst_n_q;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] tt_q;
  logic [1:0] tt_prev_q;
  logic [1:0] latch_q;
  logic [1:0] main_q;
  logic [1:0] pin_q;
  cll_reg_t mux_q;
  cll_reg_t ena_q;
  cll_reg_t opt_q;
  cll_reg_t fun_q;
  cll_reg_t ist_q;
  cll_reg_t imk_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [1:0] tt_d;
  logic [1:0] rise;
  logic [1:0] wr_clr;
  logic [1:0] clr;
  logic [1:0] rst_sel;
  logic acc;
  logic wr_ok;
  logic rd_ok;
  logic [7:0] wbyte;
  logic wr_acc;
  logic [1:0] latch_d;
  logic [1:0] main_d;
  logic [1:0] pin_d;
  logic [1:0] main_prev_q;
  logic [1:0] main_rise;
  logic [7:0] rdc_view;
  logic [7:0] rdata_d;

  // Code bit 3 gives the result for A=0,B=0 and bit 0 for A=1,B=1
  function automatic logic tt_eval(cll_func_t f, logic a, logic b);
    logic [1:0] idx;
    idx = ~{a, b};
    tt_eval = f[idx];
  endfunction

  // Function code of one channel out of the function register
  function automatic cll_func_t code_of(cll_reg_t r, logic ch);
    code_of = ch ? r[7:4] : r[3:0];
  endfunction

  // Selects the latched copy when the select bit is set
  function automatic logic route(logic use_latch, logic held, logic raw);
    route = use_latch ? held : raw;
  endfunction

  function automatic logic hit(logic [7:0] a, logic [7:0] ofs);
    hit = ((a & `CLL_ADDR_MASK) == ofs);
  endfunction

  // Reset is released through two flops; assertion stays asynchronous
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_s1_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_n_q <= 1'b0;
    end else begin
      rst_n_q <= rst_s1_q;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sync1_q <= 2'h0;
    end else begin
      sync1_q <= i_cmp_raw;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sync2_q <= 2'h0;
    end else begin
      sync2_q <= sync1_q;
    end
  end

  // table lookup, A own and B neighbour
  always_comb begin
    tt_d[0] = tt_eval(code_of(fun_q, 1'b0), sync2_q[0], sync2_q[1]);
    tt_d[1] = tt_eval(code_of(fun_q, 1'b1), sync2_q[1], sync2_q[0]);
  end

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tt_q <= 2'h0;
    end else begin
      tt_q <= tt_d;
    end
  end

  // Previous table output for edge detection
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tt_prev_q <= 2'h0;
    end else begin
      tt_prev_q <= tt_q;
    end
  end

  assign rise = tt_q & ~tt_prev_q;

  // A request is taken on its first cycle and accepted on its second
  assign acc = (i_read | i_write) & ~ack_q;
  assign wr_acc = i_write & ~i_read & ack_q;
  assign wr_ok = wr_acc & i_byteenable[0];
  assign rd_ok = acc & i_read & ~i_write;
  // Lane 0 carries the register byte
  assign wbyte = i_byteenable[0] ? i_writedata[7:0] : `CLL_RST8;
  assign rst_sel = {opt_q[`CLL_OPT_RS1], opt_q[`CLL_OPT_RS0]};

  always_comb begin
    wr_clr = 2'h0;
    if (wr_ok && i_byteenable[0] && hit(i_address, `CLL_OFS_RDC)) begin
      wr_clr[0] = ~wbyte[`CLL_RDC_L0];
      wr_clr[1] = ~wbyte[`CLL_RDC_L1];
    end
  end

  always_comb begin
    // channel 0 cleared by channel 1 edge or by write
    if (rst_sel[0]) begin
      clr[0] = rise[1];
    end else begin
      clr[0] = wr_clr[0];
    end
    // channel 1 cleared by channel 0 edge or by write
    if (rst_sel[1]) begin
      clr[1] = rise[0];
    end else begin
      clr[1] = wr_clr[1];
    end
  end

  always_comb begin
    latch_d = latch_q & ~clr;
    latch_d = latch_d | tt_q;
  end

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      latch_q <= 2'h0;
    end else begin
      latch_q <= latch_d;
    end
  end

  always_comb begin
    main_d[0] = route(opt_q[`CLL_OPT_DS0], latch_q[0], tt_q[0]);
    main_d[1] = route(opt_q[`CLL_OPT_DS1], latch_q[1], tt_q[1]);
    pin_d[0] = route(opt_q[`CLL_OPT_PIN0], latch_q[0], tt_q[0]);
    pin_d[1] = route(opt_q[`CLL_OPT_PIN1], latch_q[1], tt_q[1]);
  end

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      main_q <= 2'h0;
    end else begin
      main_q <= main_d;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_q <= 2'h0;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign o_main_out = main_q;
  assign o_pin_out = pin_q;

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mux_q <= `CLL_RST8;
    end else if (wr_ok && hit(i_address, `CLL_OFS_MUX)) begin
      mux_q <= wbyte;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ena_q <= `CLL_RST8;
    end else if (wr_ok && hit(i_address, `CLL_OFS_ENA)) begin
      ena_q <= wbyte & `CLL_ENA_MASK;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      opt_q <= `CLL_RST8;
    end else if (wr_ok && hit(i_address, `CLL_OFS_OPT)) begin
      opt_q <= wbyte;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fun_q <= `CLL_RST8;
    end else if (wr_ok && hit(i_address, `CLL_OFS_FUN)) begin
      fun_q <= wbyte;
    end
  end

  // Interrupt mask, same layout as the event bits
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      imk_q <= `CLL_RST8;
    end else if (wr_ok && hit(i_address, `CLL_OFS_IMK)) begin
      imk_q <= wbyte & `CLL_IST_MASK;
    end
  end

  // Previous main output for event detection
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      main_prev_q <= 2'h0;
    end else begin
      main_prev_q <= main_q;
    end
  end

  assign main_rise = main_q & ~main_prev_q;

  // Sticky event bits: a read clears what it returned, set wins
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ist_q <= `CLL_RST8;
    end else if (rd_ok && hit(i_address, `CLL_OFS_IST)) begin
      ist_q <= {6'h00, main_rise};
    end else begin
      ist_q <= ist_q | {6'h00, main_rise};
    end
  end

  assign o_irq = |(ist_q & imk_q);

  assign rdc_view = {2'h0, sync2_q[1], sync2_q[0], 2'h0, latch_q[1],
                     latch_q[0]};

  // Register read multiplexer; unmapped addresses read zero
  always_comb begin
    rdata_d = `CLL_RST8;
    unique case (1'b1)
      hit(i_address, `CLL_OFS_RDC): rdata_d = rdc_view;
      hit(i_address, `CLL_OFS_MUX): rdata_d = mux_q;
      hit(i_address, `CLL_OFS_ENA): rdata_d = ena_q;
      hit(i_address, `CLL_OFS_OPT): rdata_d = opt_q;
      hit(i_address, `CLL_OFS_FUN): rdata_d = fun_q;
      hit(i_address, `CLL_OFS_IST): rdata_d = ist_q;
      hit(i_address, `CLL_OFS_IMK): rdata_d = imk_q;
      default: rdata_d = `CLL_RST8;
    endcase
  end

  // One wait state: ack marks the second cycle of every request
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc;
    end
  end

  // Read data are captured on the first cycle and stand on the second
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_ok) begin
      rdata_q <= {24'h00_0000, rdata_d};
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign o_readdata = rdata_q;
  // Waitrequest falls on the second cycle of each request
  assign o_waitrequest = (i_read | i_write) & ~ack_q;

  assign o_cmp_enable = {ena_q[`CLL_ENA_1], ena_q[`CLL_ENA_0]};

  assign o_ch1_input_sel_p = mux_q[7:6];
  assign o_ch1_input_sel_n = mux_q[5:4];
  assign o_ch0_input_sel_p = mux_q[3:2];
  assign o_ch0_input_sel_n = mux_q[1:0];

  // Connections of each comparator to the analog output
  assign o_analog_out_connect = {opt_q[`CLL_OPT_INT1], opt_q[`CLL_OPT_INT0]};

endmodule

// [tb/cll_unit_monitor.sv]
// Port checker for the comparator unit
`timescale 1ns/1ps
module cll_unit_monitor
  import cll_pkg::*;
(
  // Bus
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  // Control outputs
  input wire logic [1:0] o_cmp_enable,
  input wire logic [1:0] o_ch0_input_sel_p,
  input wire logic [1:0] o_ch0_input_sel_n,
  input wire logic [1:0] o_ch1_input_sel_p,
  input wire logic [1:0] o_ch1_input_sel_n
);
  logic [7:0] sel;
  assign sel = {o_ch1_input_sel_p, o_ch1_input_sel_n, o_ch0_input_sel_p,
    o_ch0_input_sel_n};
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_wr(a);
    i_write && !o_waitrequest && i_byteenable[0] && i_address == a;
  endsequence
  sequence s_rd(a);
    i_read && !o_waitrequest && i_address == a;
  endsequence
  a_one_wait: assert property ((i_read || i_write) && o_waitrequest
    |=> !o_waitrequest) else $error("long wait");
  a_upper_zero: assert property (i_read && !o_waitrequest
    |-> o_readdata[31:8] == 24'h0) else $error("upper bits");
  a_enable_write: assert property (s_wr(8'h7A)
    |=> o_cmp_enable == {$past(i_writedata[4]), $past(i_writedata[0])})
    else $error("enable write");
  a_select_write: assert property (s_wr(8'h79)
    |=> sel == $past(i_writedata[7:0])) else $error("select write");
  a_enable_read: assert property (s_rd(8'h7A)
    |-> {o_readdata[4], o_readdata[0]} == o_cmp_enable)
    else $error("enable read");
  a_select_read: assert property (s_rd(8'h79)
    |-> o_readdata[7:0] == sel) else $error("select read");
  a_unmapped_zero: assert property (i_read && !o_waitrequest &&
    (i_address < 8'h78 || i_address > 8'h7E) |-> o_readdata == 32'h0)
    else $error("unmapped read");
  a_lane_off: assert property (i_write && !o_waitrequest && !i_byteenable[0]
    |=> $stable(o_cmp_enable)) else $error("lane ignored");
endmodule
bind cll_comparator_unit cll_unit_monitor u_mon (.i_clk, .i_reset_n,
  .i_address, .i_read, .i_write, .i_writedata, .i_byteenable, .o_readdata,
  .o_waitrequest, .o_cmp_enable, .o_ch0_input_sel_p, .o_ch0_input_sel_n,
  .o_ch1_input_sel_p, .o_ch1_input_sel_n);

// [tb/cll_cmp_model.sv]
// Behavioural model of the two analog comparators
`timescale 1ns/1ps
module cll_cmp_model (
  // Bench control
  input wire logic [1:0] i_level,
  input wire logic i_slow,
  // Unit side
  input wire logic [1:0] i_enable,
  output logic [1:0] o_cmp
);
  always @(i_level, i_enable, i_slow) begin
    o_cmp <= #(i_slow ? 13 : 1) i_level & i_enable;
  end
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the comparator unit
`timescale 1ns/1ps
module tb_top;
  import cll_pkg::*;
  typedef struct packed {cll_func_t code; logic [3:0] tv;} cll_row_t;
  cll_row_t rows[8] = '{'{4'h0, 4'h0}, '{4'h3, 4'hC}, '{4'h5, 4'hA},
    '{4'h6, 4'h6}, '{4'h7, 4'hE}, '{4'h8, 4'h1}, '{4'hF, 4'hF}, '{4'h1, 4'h8}};
  logic i_clk, i_reset_n, i_read, i_write, o_waitrequest, o_irq, slow;
  logic [7:0] i_address;
  logic [31:0] i_writedata, o_readdata, rd;
  logic [3:0] i_byteenable, e;
  logic [1:0] i_cmp_raw, level, o_cmp_enable, o_main_out, o_pin_out;
  logic [1:0] s0p, s0n, s1p, s1n, aoc;
  int fails = 0, checked = 0, cycles = 0;
  cll_comparator_unit dut (.i_clk, .i_reset_n, .i_address, .i_read,
    .i_write, .i_writedata, .i_byteenable, .o_readdata, .o_waitrequest,
    .i_cmp_raw, .o_cmp_enable, .o_ch0_input_sel_p(s0p),
    .o_ch0_input_sel_n(s0n), .o_ch1_input_sel_p(s1p),
    .o_ch1_input_sel_n(s1n), .o_analog_out_connect(aoc), .o_main_out,
    .o_pin_out, .o_irq);
  cll_cmp_model u_cmp (.i_level(level), .i_slow(slow),
    .i_enable(o_cmp_enable), .o_cmp(i_cmp_raw));
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [7:0] d, input logic [3:0] be);
    i_address <= a;
    i_writedata <= {24'h0, d};
    i_byteenable <= be;
    i_read <= !w;
    i_write <= w;
    do @(posedge i_clk); while (o_waitrequest !== 1'b0);
    rd = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask
  task automatic rdk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00, 4'hF);
    check(rd, exp);
  endtask
  task automatic wrap_up;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    i_reset_n = 1'b0;
    i_read = 1'b0;
    i_write = 1'b0;
    i_address = 8'h00;
    i_writedata = 32'h0;
    i_byteenable = 4'h0;
    level = 2'b00;
    slow = 1'b0;
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    for (int a = 8'h78; a < 8'h7F; a++) rdk(8'(a), 32'h0);
    wr(8'h7A, 8'h11);
    wr(8'h79, 8'hE4);
    rdk(8'h79, 32'hE4);
    bus(1'b1, 8'h7A, 8'h00, 4'h0);
    rdk(8'h7A, 32'h11);
    rdk(8'h80, 32'h0);
    wr(8'h7B, 8'h88);
    check(32'(aoc), 32'h3);
    wr(8'h7B, 8'h00);
    foreach (rows[r]) begin
      wr(8'h7C, {4'h3, rows[r].code});
      slow <= r[0];
      for (int i = 0; i < 4; i++) begin
        level <= {i[0], i[1]};
        repeat (12) @(posedge i_clk);
        e = {i[0], rows[r].tv[i], i[0], rows[r].tv[i]};
        check(32'({o_pin_out, o_main_out}), 32'(e));
        bus(1'b0, 8'h78, 8'h00, 4'hF);
        check(32'({rd[31:6], rd[3:2]}), 32'h0);
        check(32'(rd[5:4]), 32'(level));
      end
    end
    level <= 2'b00;
    slow <= 1'b0;
    repeat (8) @(posedge i_clk);
    wr(8'h7C, 8'h03);
    wr(8'h78, 8'h00);
    wr(8'h7B, 8'h05);
    bus(1'b0, 8'h7D, 8'h00, 4'hF);
    wr(8'h7E, 8'h01);
    level <= 2'b01;
    repeat (10) @(posedge i_clk);
    level <= 2'b00;
    repeat (10) @(posedge i_clk);
    check(32'({o_irq, o_pin_out, o_main_out}), 32'h15);
    rdk(8'h78, 32'h01);
    rdk(8'h7D, 32'h01);
    check(32'(o_irq), 32'h0);
    wr(8'h78, 8'h00);
    repeat (6) @(posedge i_clk);
    check(32'(o_main_out), 32'h0);
    wr(8'h7E, 8'h00);
    wr(8'h7C, 8'h33);
    for (int c = 0; c < 2; c++) begin
      wr(8'h7B, 8'h07 << (4 * c));
      level <= 2'(1 << c);
      repeat (10) @(posedge i_clk);
      level <= 2'b00;
      wr(8'h78, 8'h00);
      repeat (8) @(posedge i_clk);
      check(32'({o_irq, o_main_out[c]}), 32'h1);
      level <= 2'(2 >> c);
      repeat (10) @(posedge i_clk);
      check(32'(o_main_out[c]), 32'h0);
      level <= 2'b00;
    end
    rdk(8'h7D, 32'h03);
    wrap_up();
  end
endmodule
